// *** core/apu_pkg.sv ***
/*
  Shared constants for the pack/unpack/permute ALU slice: register map,
  control and flag field positions, operation and numeric-mode codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package apu_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_OPA = 8'h00;
  localparam logic [7:0] OFF_OPB = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h20;
  localparam logic [7:0] OFF_FLAGS = 8'h24;
  localparam logic [7:0] OFF_RES = 8'h30;

  // Control word fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_WIDE = 4;
  localparam int CTRL_SIZE_LSB = 5;
  localparam int CTRL_AS_LSB = 7;
  localparam int CTRL_NUM_LSB = 9;
  localparam int CTRL_TRUNC = 12;
  localparam int CTRL_NF = 13;
  localparam logic [31:0] CTRL_MASK = 32'h0000_3fff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Flag bit positions
  localparam int FLG_ZERO = 0;
  localparam int FLG_NEG = 1;
  localparam int FLG_OVF = 2;
  localparam int FLG_CARRY = 3;
  localparam int FLG_STICKY = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h00;

  // Operation codes
  localparam logic [3:0] OP_AND = 4'h0;
  localparam logic [3:0] OP_ANDN = 4'h1;
  localparam logic [3:0] OP_OR = 4'h2;
  localparam logic [3:0] OP_XOR = 4'h3;
  localparam logic [3:0] OP_NOT = 4'h4;
  localparam logic [3:0] OP_EXPAND = 4'h5;
  localparam logic [3:0] OP_COMPACT = 4'h6;
  localparam logic [3:0] OP_MERGE = 4'h7;
  localparam logic [3:0] OP_PERMUTE = 4'h8;

  // Add/subtract selection
  localparam logic [1:0] AS_NONE = 2'h0;
  localparam logic [1:0] AS_ADD = 2'h1;
  localparam logic [1:0] AS_SUB = 2'h2;

  // Numeric modes
  localparam logic [2:0] NUM_FRAC = 3'h0;
  localparam logic [2:0] NUM_INT = 3'h1;
  localparam logic [2:0] NUM_IS = 3'h2;
  localparam logic [2:0] NUM_ISU = 3'h3;
  localparam logic [2:0] NUM_U = 3'h4;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// *** core/apu_alu_slice.sv ***
/*
  Pack/unpack/permute ALU slice behind an AXI4-Lite slave: logical ops,
  expand, compact, merge and byte permute with status flags.
  Assumes a single clock aclk with synchronous active-low reset, and a
  master that keeps at most one write and one read under way.
*/
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module apu_expand_lane
  import apu_pkg::*;
#(
  parameter int W = 8
) (
  // Lane operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  // Options
  input wire logic [1:0] addsub,
  input wire logic uns,
  input wire logic frac,
  // Lane result
  output logic [2*W-1:0] r,
  output logic ovf
);
  logic [W:0] ea;
  logic [W:0] eb;
  logic [W:0] s;
  logic fits;
  logic [W-1:0] fsat;

  assign ea = {(uns ? 1'b0 : a[W-1]), a};
  assign eb = (addsub == AS_NONE) ? '0 : {(uns ? 1'b0 : b[W-1]), b};
  assign s = (addsub == AS_SUB) ? (ea - eb) : (ea + eb);
  assign fits = (s[W] == s[W-1]);
  assign fsat = s[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
  // Fractional: high part, zero fill; integer: right aligned, sign fill
  assign r = frac ? {(fits ? s[W-1:0] : fsat), {W{1'b0}}}
                  : {{(W-1){s[W]}}, s};
  assign ovf = frac ? ~fits : (uns & s[W]);
endmodule

module apu_compact_lane
  import apu_pkg::*;
#(
  parameter int H = 16
) (
  // Lane operands
  input wire logic [2*H-1:0] a,
  input wire logic [2*H-1:0] b,
  // Options
  input wire logic [1:0] addsub,
  input wire logic [2:0] mode,
  input wire logic trunc,
  // Lane result
  output logic [H-1:0] r,
  output logic ovf
);
  logic uns;
  logic frac;
  logic [2*H:0] ea;
  logic [2*H:0] eb;
  logic [2*H:0] s;
  logic [H-1:0] hi;
  logic rup;
  logic fov;
  logic [H-1:0] smax;
  logic [H-1:0] smin;
  logic [H-1:0] fr;
  logic [H-1:0] kept;
  logic iov;
  logic [H-1:0] ir;

  assign uns = (mode == NUM_ISU) || (mode == NUM_U);
  assign frac = (mode == NUM_FRAC);
  assign ea = {(uns ? 1'b0 : a[2*H-1]), a};
  assign eb = (addsub == AS_NONE) ? '0 : {(uns ? 1'b0 : b[2*H-1]), b};
  assign s = (addsub == AS_SUB) ? (ea - eb) : (ea + eb);
  assign smax = {1'b0, {(H-1){1'b1}}};
  assign smin = {1'b1, {(H-1){1'b0}}};
  // Round to nearest even unless truncating
  assign hi = s[2*H-1:H];
  assign rup = ~trunc & s[H-1] & ((|s[H-2:0]) | hi[0]);
  assign fov = (s[2*H] != s[2*H-1]) | (rup & (hi == smax));
  assign fr = fov ? (s[2*H] ? smin : smax) : (hi + {{(H-1){1'b0}}, rup});
  // Integer: low half kept, upper bits judge overflow and pick the saturation sign
  assign kept = s[H-1:0];
  assign iov = uns ? (s[2*H:H] != '0)
                   : (s[2*H:H] != {(H+1){kept[H-1]}});
  assign ir = (mode == NUM_IS && iov) ? (s[2*H] ? smin : smax) :
              (mode == NUM_ISU && iov) ? {H{1'b1}} : kept;
  assign r = frac ? fr : ir;
  assign ovf = frac ? fov : iov;
endmodule

// Notes on behaviour
// - AND, ANDNOT, OR, XOR, NOT to destination
// - Zero flag set when result all zero
// - Negative flag takes result top bit
// - Logic/merge clear overflow; carry always cleared
// - No-flag option keeps flags, writes result
// - Expand adds/subtracts lanes, then widens them
// - Missing second operand: no add/subtract
// - Fractional expand: high part, zero fill
// - Integer expand: right aligned, sign/zero fill
// - Expand lane counts follow single/pair source
// - Expand overflow sets overflow and sticky
// - Compact adds/subtracts pairs, then narrows lanes
// - Compact normal, short, long, quad narrowings
// - Fractional compact keeps high half, rounds
// - Fractional round-up overflow saturates signed
// - Integer compact keeps low half
// - Signed overflow: upper bits differ from sign
// - Signed saturation to max or min
// - Unsigned saturation: nonzero upper gives ones
// - Compact overflow sets flags, else clears overflow
// - Merge interleaves byte/short lanes of operands
// - Permute nibble k picks destination byte k
// - Codes 0-7 pick bytes; top bit reserved
// - Permute allows duplicates, leaves flags alone
module apu_alu_slice
  import apu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Bus state
  logic aw_held_r;
  logic [7:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Block state
  logic [31:0] opa_r [0:3];
  logic [31:0] opb_r [0:3];
  logic [31:0] ctrl_r;
  logic [4:0] flags_r;
  logic [127:0] res_r;
  logic go_r;

  // Write decode
  logic do_write;
  logic w_opa;
  logic w_opb;
  logic w_ctrl;
  logic w_flags;
  logic w_ok;
  logic [31:0] bmask;
  logic [31:0] wmerge_a;
  logic [31:0] wmerge_b;
  logic [31:0] wmerge_c;

  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign w_opa = (aw_addr_r[7:4] == OFF_OPA[7:4]);
  assign w_opb = (aw_addr_r[7:4] == OFF_OPB[7:4]);
  assign w_ctrl = (aw_addr_r[7:2] == OFF_CTRL[7:2]);
  assign w_flags = (aw_addr_r[7:2] == OFF_FLAGS[7:2]);
  assign w_ok = w_opa | w_opb | w_ctrl | w_flags;
  assign bmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wmerge_a = (opa_r[aw_addr_r[3:2]] & ~bmask) | (w_data_r & bmask);
  assign wmerge_b = (opb_r[aw_addr_r[3:2]] & ~bmask) | (w_data_r & bmask);
  assign wmerge_c = ((ctrl_r & ~bmask) | (w_data_r & bmask)) & CTRL_MASK;

  // Read decode
  logic r_opa;
  logic r_opb;
  logic r_ctrl;
  logic r_flags;
  logic r_res;
  logic [31:0] rd_word;

  assign r_opa = (s_axi_araddr[7:4] == OFF_OPA[7:4]);
  assign r_opb = (s_axi_araddr[7:4] == OFF_OPB[7:4]);
  assign r_ctrl = (s_axi_araddr[7:2] == OFF_CTRL[7:2]);
  assign r_flags = (s_axi_araddr[7:2] == OFF_FLAGS[7:2]);
  assign r_res = (s_axi_araddr[7:4] == OFF_RES[7:4]);
  assign rd_word = r_opa ? opa_r[s_axi_araddr[3:2]] :
                   r_opb ? opb_r[s_axi_araddr[3:2]] :
                   r_ctrl ? ctrl_r :
                   r_flags ? {27'h0000000, flags_r} :
                   r_res ? res_r[{s_axi_araddr[3:2], 5'h00} +: 32] : 32'h0000_0000;

  // Control fields
  logic [3:0] c_op;
  logic c_wide;
  logic [1:0] c_size;
  logic [1:0] c_as;
  logic [2:0] c_num;
  logic c_trunc;
  logic c_nf;
  logic [127:0] opa;
  logic [127:0] opb;

  assign c_op = ctrl_r[CTRL_OP_LSB +: 4];
  assign c_wide = ctrl_r[CTRL_WIDE];
  assign c_size = ctrl_r[CTRL_SIZE_LSB +: 2];
  assign c_as = ctrl_r[CTRL_AS_LSB +: 2];
  assign c_num = ctrl_r[CTRL_NUM_LSB +: 3];
  assign c_trunc = ctrl_r[CTRL_TRUNC];
  assign c_nf = ctrl_r[CTRL_NF];
  assign opa = {opa_r[3], opa_r[2], opa_r[1], opa_r[0]};
  assign opb = {opb_r[3], opb_r[2], opb_r[1], opb_r[0]};

  logic is_log;
  logic is_exp;
  logic is_cmp;
  logic is_mrg;
  logic is_prm;

  assign is_log = (c_op <= OP_NOT);
  assign is_exp = (c_op == OP_EXPAND);
  assign is_cmp = (c_op == OP_COMPACT);
  assign is_mrg = (c_op == OP_MERGE);
  assign is_prm = (c_op == OP_PERMUTE);

  // Logical group
  logic [63:0] lg_raw;
  logic [63:0] lg_res;

  assign lg_raw = (c_op == OP_AND) ? (opa[63:0] & opb[63:0]) :
                  (c_op == OP_ANDN) ? (opa[63:0] & ~opb[63:0]) :
                  (c_op == OP_OR) ? (opa[63:0] | opb[63:0]) :
                  (c_op == OP_XOR) ? (opa[63:0] ^ opb[63:0]) : ~opa[63:0];
  assign lg_res = c_wide ? lg_raw : {32'h0000_0000, lg_raw[31:0]};

  // Expand, merge and permute lanes
  logic ex_uns;
  logic ex_frac;
  logic [127:0] exb;
  logic [127:0] exs;
  logic [7:0] exb_ov;
  logic [3:0] exs_ov;
  logic [7:0] lb_en;
  logic [3:0] ls_en;
  logic [127:0] mgb;
  logic [127:0] mgs;
  logic [63:0] pm_res;

  assign ex_uns = (c_num == NUM_U) || (c_num == NUM_ISU);
  assign ex_frac = (c_num == NUM_FRAC);

  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_byte
      logic [15:0] er;
      logic [3:0] nib;
      apu_expand_lane #(.W(8)) u_ex (
        .a(opa[8*k +: 8]),
        .b(opb[8*k +: 8]),
        .addsub(c_as),
        .uns(ex_uns),
        .frac(ex_frac),
        .r(er),
        .ovf(exb_ov[k])
      );
      assign lb_en[k] = c_wide | (k < 4);
      assign exb[16*k +: 16] = lb_en[k] ? er : 16'h0000;
      assign mgb[16*k +: 16] = lb_en[k] ? {opb[8*k +: 8], opa[8*k +: 8]} : 16'h0000;
      assign nib = opb[4*k +: 4];
      // Duplicate picks are allowed
      assign pm_res[8*k +: 8] = nib[3] ? 8'h00 :
                                opa[{nib[2:0], 3'h0} +: 8];
    end
    for (k = 0; k < 4; k++) begin : g_short
      logic [31:0] er;
      apu_expand_lane #(.W(16)) u_ex (
        .a(opa[16*k +: 16]),
        .b(opb[16*k +: 16]),
        .addsub(c_as),
        .uns(ex_uns),
        .frac(ex_frac),
        .r(er),
        .ovf(exs_ov[k])
      );
      assign ls_en[k] = c_wide | (k < 2);
      assign exs[32*k +: 32] = ls_en[k] ? er : 32'h0000_0000;
      assign mgs[32*k +: 32] = ls_en[k] ? {opb[16*k +: 16], opa[16*k +: 16]} : 32'h0;
    end
  endgenerate

  logic [127:0] ex_res;
  logic ex_ovf;
  logic [127:0] mg_res;

  assign ex_res = (c_size == 2'h0) ? exb : exs;
  assign ex_ovf = (c_size == 2'h0) ? |(exb_ov & lb_en) : |(exs_ov & ls_en);
  assign mg_res = (c_size == 2'h0) ? mgb : mgs;

  // Compact lanes
  logic [1:0] cp_as;
  logic [31:0] cp0;
  logic [1:0] cp0_ov;
  logic [31:0] cp1;
  logic [3:0] cp1_ov;
  logic [31:0] cp2;
  logic cp2_ov;
  logic [63:0] cp3;
  logic cp3_ov;

  // Long and quad compact have no second operand
  assign cp_as = c_size[1] ? AS_NONE : c_as;

  generate
    for (k = 0; k < 2; k++) begin : g_cnorm
      apu_compact_lane #(.H(16)) u_cp (
        .a(opa[32*k +: 32]),
        .b(opb[32*k +: 32]),
        .addsub(cp_as),
        .mode(c_num),
        .trunc(c_trunc),
        .r(cp0[16*k +: 16]),
        .ovf(cp0_ov[k])
      );
    end
    for (k = 0; k < 4; k++) begin : g_cshort
      apu_compact_lane #(.H(8)) u_cp (
        .a(opa[16*k +: 16]),
        .b(opb[16*k +: 16]),
        .addsub(cp_as),
        .mode(c_num),
        .trunc(c_trunc),
        .r(cp1[8*k +: 8]),
        .ovf(cp1_ov[k])
      );
    end
  endgenerate

  apu_compact_lane #(.H(32)) u_clong (
    .a(opa[63:0]),
    .b(opb[63:0]),
    .addsub(cp_as),
    .mode(c_num),
    .trunc(c_trunc),
    .r(cp2),
    .ovf(cp2_ov)
  );

  apu_compact_lane #(.H(64)) u_cquad (
    .a(opa),
    .b(opb),
    .addsub(cp_as),
    .mode(c_num),
    .trunc(c_trunc),
    .r(cp3),
    .ovf(cp3_ov)
  );

  logic [63:0] cp_res;
  logic cp_ovf;

  assign cp_res = (c_size == 2'h0) ? {32'h0000_0000, cp0} :
                  (c_size == 2'h1) ? {32'h0000_0000, cp1} :
                  (c_size == 2'h2) ? {32'h0000_0000, cp2} : cp3;
  assign cp_ovf = (c_size == 2'h0) ? |cp0_ov :
                  (c_size == 2'h1) ? |cp1_ov :
                  (c_size == 2'h2) ? cp2_ov : cp3_ov;

  // Result and flags
  logic valid_op;
  logic [127:0] dp_res;
  logic [6:0] res_msb;
  logic ovf_any;
  logic flag_upd;
  logic sticky_set;
  logic sticky_clr;

  assign valid_op = is_log | is_exp | is_cmp | is_mrg | is_prm;
  assign dp_res = is_log ? {64'h0, lg_res} :
                  is_exp ? ex_res :
                  is_cmp ? {64'h0, cp_res} :
                  is_mrg ? mg_res :
                  is_prm ? {64'h0, pm_res} : 128'h0;
  assign res_msb = is_log ? (c_wide ? 7'h3f : 7'h1f) :
                   (is_exp | is_mrg) ? (c_wide ? 7'h7f : 7'h3f) :
                   (c_size == 2'h3) ? 7'h3f : 7'h1f;
  assign ovf_any = (is_exp & ex_ovf) | (is_cmp & cp_ovf);
  assign flag_upd = go_r & valid_op & ~is_prm & ~c_nf;
  assign sticky_set = flag_upd & ovf_any;
  assign sticky_clr = do_write & w_flags & w_strb_r[0] & w_data_r[FLG_STICKY];

  // Write address/data capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= w_ok ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= (r_opa | r_opb | r_ctrl | r_flags | r_res) ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Operand and control registers; a control write issues the operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        opa_r[i] <= 32'h0000_0000;
        opb_r[i] <= 32'h0000_0000;
      end
      ctrl_r <= CTRL_RESET;
      go_r <= 1'b0;
    end else begin
      go_r <= do_write & w_ctrl;
      if (do_write && w_opa) begin
        opa_r[aw_addr_r[3:2]] <= wmerge_a;
      end
      if (do_write && w_opb) begin
        opb_r[aw_addr_r[3:2]] <= wmerge_b;
      end
      if (do_write && w_ctrl) begin
        ctrl_r <= wmerge_c;
      end
    end
  end

  // Execute: result and flags retire together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_r <= 128'h0;
      flags_r <= FLAGS_RESET;
    end else begin
      if (go_r && valid_op) begin
        res_r <= dp_res;
      end
      if (flag_upd) begin
        flags_r[FLG_ZERO] <= (dp_res == 128'h0);
        flags_r[FLG_NEG] <= dp_res[res_msb];
        flags_r[FLG_OVF] <= ovf_any;
        flags_r[FLG_CARRY] <= 1'b0;
      end
      // Set wins over a same-cycle clear; permute never touches flags
      flags_r[FLG_STICKY] <= sticky_set | (flags_r[FLG_STICKY] & ~sticky_clr);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

// *** test/apu_slice_assertions.sv ***
/* Bus timing and decode checks bound to apu_alu_slice.
   Sees its ports only; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module apu_slice_chk
  import apu_pkg::*;
(
  // Clock, reset, write side
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;

  rd_lat_a: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read answer late");
  wr_lat_a: assert property (aw_hs && w_hs |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  hole_rd_a: assert property (ar_hs && s_axi_araddr == 8'h28 |=>
    s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  ctrl_rd_a: assert property (ar_hs && s_axi_araddr == OFF_CTRL |=> s_axi_rdata[31:14] == 18'h0)
    else $error("control spare bits set");
  ro_wr_a: assert property (aw_hs && w_hs && s_axi_awaddr[7:4] == 4'h3 |->
    ##2 s_axi_bresp == RESP_DECERR) else $error("result write accepted");

  cover property (ar_hs && s_axi_araddr == 8'h28);
  cover property (aw_hs && s_axi_awaddr == OFF_CTRL);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
endmodule

bind apu_alu_slice apu_slice_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);

// *** test/apu_host_bfm.sv ***
/* Bus master standing in for the sequencer.
   Assumes the slave answers; the watchdog ends any hang. */
`timescale 1ns/1ps
module apu_host_bfm (
  // Clock and write side
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read side
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Each request stands until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// *** test/tb.sv ***
/* Bench for the ALU slice: ops loaded and read back over the bus.
   Assumes apu_host_bfm as bus master. */
`timescale 1ns/1ps
module tb
  import apu_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, flg, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [63:0] res;
  int error_cnt = 0;
  int n_tests = 0;

  initial begin
    forever #10 aclk = ~aclk;
  end

  apu_alu_slice u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  apu_host_bfm u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
    u_host.wr(a, v, s, rsp);
    chk(rsp, RESP_OKAY);
  endtask

  task automatic r(input logic [7:0] a, output logic [31:0] v);
    u_host.rd(a, v, rsp);
    chk(rsp, RESP_OKAY);
  endtask

  // Control word; sw is {size, wide}, tn is {no-flag, truncate}
  function automatic logic [31:0] cw(logic [3:0] op, logic [2:0] sw, logic [1:0] as,
      logic [2:0] nm, logic [1:0] tn);
    return 32'(op) | 32'(sw) << CTRL_WIDE | 32'(as) << CTRL_AS_LSB | 32'(nm) << CTRL_NUM_LSB
      | 32'(tn) << CTRL_TRUNC;
  endfunction

  function automatic logic [31:0] fl(logic ov, logic sk, logic n, logic z);
    return {27'h0, sk, 1'b0, ov, n, z};
  endfunction

  task automatic exe(input logic [63:0] a, input logic [63:0] b, input logic [31:0] c);
    w(OFF_OPA, a[31:0]);
    w(OFF_OPA + 8'h04, a[63:32]);
    w(OFF_OPB, b[31:0]);
    w(OFF_OPB + 8'h04, b[63:32]);
    w(OFF_CTRL, c);
    r(OFF_RES, res[31:0]);
    r(OFF_RES + 8'h04, res[63:32]);
    r(OFF_FLAGS, flg);
  endtask

  task automatic t_logic();
    logic [31:0] a = 32'h8000_0009;
    logic [31:0] b = 32'h0000_0006;
    logic [31:0] e [5];
    e = '{a & b, a & ~b, a | b, a ^ b, ~a};
    r(OFF_FLAGS, flg);
    chk(flg, 64'(FLAGS_RESET));
    for (int i = 0; i < 5; i++) begin
      exe({32'h0, a}, {32'h0, b}, cw(4'(i), 3'h0, AS_NONE, NUM_FRAC, 2'h0));
      chk(res, {32'h0, e[i]});
      chk(flg, fl(1'b0, 1'b0, e[i][31], e[i] == 32'h0));
    end
  endtask

  task automatic t_expand();
    exe(64'h70, 64'h20, cw(OP_EXPAND, 3'h0, AS_ADD, NUM_FRAC, 2'h0));
    chk(res, 64'h7f00);
    chk(flg, fl(1'b1, 1'b1, 1'b0, 1'b0));
    exe(64'h8000_0080, 64'h5, cw(OP_EXPAND, 3'h0, AS_NONE, NUM_INT, 2'h0));
    chk(res, 64'hff80_0000_0000_ff80);
    chk(flg, fl(1'b0, 1'b1, 1'b1, 1'b0));
    exe(64'h1, 64'h2, cw(OP_EXPAND, 3'h0, AS_SUB, NUM_U, 2'h0));
    chk(res, 64'hffff);
    chk(flg, fl(1'b1, 1'b1, 1'b0, 1'b0));
    exe(64'h1234, 64'h0, cw(OP_EXPAND, 3'h2, AS_NONE, NUM_FRAC, 2'h0));
    chk(res, 64'h1234_0000);
    w(OFF_FLAGS, 32'h10);
    r(OFF_FLAGS, flg);
    chk(flg, 64'h0);
  endtask

  task automatic t_compact();
    logic [63:0] s4 = 64'hffff_0005_fe00_0180;
    exe(64'h1235_8000_1234_8000, 64'h0, cw(OP_COMPACT, 3'h0, AS_NONE, NUM_FRAC, 2'h0));
    chk(res, 64'h1236_1234);
    exe(64'h1235_8000_1234_8000, 64'h0, cw(OP_COMPACT, 3'h0, AS_NONE, NUM_FRAC, 2'h1));
    chk(res, 64'h1235_1234);
    exe(64'h7fff_c000, 64'h0, cw(OP_COMPACT, 3'h0, AS_NONE, NUM_FRAC, 2'h0));
    chk(res, 64'h7fff);
    chk(flg, fl(1'b1, 1'b1, 1'b0, 1'b0));
    exe(s4, 64'h0, cw(OP_COMPACT, 3'h2, AS_NONE, NUM_IS, 2'h0));
    chk(res, 64'hff05_807f);
    chk(flg, fl(1'b1, 1'b1, 1'b1, 1'b0));
    exe(s4, 64'h0, cw(OP_COMPACT, 3'h2, AS_NONE, NUM_ISU, 2'h0));
    chk(res, 64'hff05_ffff);
    exe(s4, 64'h0, cw(OP_COMPACT, 3'h2, AS_NONE, NUM_INT, 2'h0));
    chk(res, 64'hff05_0080);
    exe(64'h5, 64'h3, cw(OP_COMPACT, 3'h0, AS_SUB, NUM_INT, 2'h0));
    chk(res, 64'h2);
    chk(flg, fl(1'b0, 1'b1, 1'b0, 1'b0));
    exe(64'h1_0000_0003, 64'h0, cw(OP_COMPACT, 3'h4, AS_NONE, NUM_INT, 2'h0));
    chk(res, 64'h3);
    chk(flg, fl(1'b1, 1'b1, 1'b0, 1'b0));
  endtask

  task automatic t_merge_permute();
    exe(64'h4433_2211, 64'h8877_6655, cw(OP_MERGE, 3'h0, AS_NONE, NUM_FRAC, 2'h0));
    chk(res, 64'h8844_7733_6622_5511);
    chk(flg, fl(1'b0, 1'b1, 1'b1, 1'b0));
    exe(64'h4433_2211, 64'h8877_6655, cw(OP_MERGE, 3'h2, AS_NONE, NUM_FRAC, 2'h0));
    chk(res, 64'h8877_4433_6655_2211);
    exe(64'h0123_4567_89ab_cdef, 64'h0317_2454, cw(OP_PERMUTE, 3'h0, AS_NONE, NUM_FRAC, 2'h0));
    chk(res, 64'hef89_cd01_ab67_4567);
    chk(flg, fl(1'b0, 1'b1, 1'b1, 1'b0));
    exe(64'h0123_4567_89ab_cdef, 64'h8000_00f0, cw(OP_PERMUTE, 3'h0, AS_NONE, NUM_FRAC, 2'h0));
    chk(res, 64'h00ef_efef_efef_00ef);
  endtask

  task automatic t_noflag();
    w(OFF_FLAGS, 32'h10);
    exe(64'h7fff_c000, 64'h0, cw(OP_COMPACT, 3'h0, AS_NONE, NUM_FRAC, 2'h2));
    chk(res, 64'h7fff);
    chk(flg, fl(1'b0, 1'b0, 1'b1, 1'b0));
    exe(64'h0, 64'h0, cw(OP_NOT, 3'h0, AS_NONE, NUM_FRAC, 2'h2));
    chk(res, 64'hffff_ffff);
    chk(flg, fl(1'b0, 1'b0, 1'b1, 1'b0));
  endtask

  task automatic t_bus();
    u_host.rd(8'h28, d, rsp);
    chk({rsp, d}, {RESP_DECERR, 32'h0});
    u_host.wr(OFF_RES, 32'h1, 4'hf, rsp);
    chk(rsp, RESP_DECERR);
    r(OFF_RES, d);
    chk(d, 32'hffff_ffff);
    w(OFF_OPA, 32'haabb_ccdd);
    w(OFF_OPA, 32'h1122_3344, 4'h5);
    r(OFF_OPA, d);
    chk(d, 32'haa22_cc44);
    w(OFF_CTRL, 32'hffff_c00f);
    r(OFF_CTRL, d);
    chk(d, 32'hffff_c00f & CTRL_MASK);
  endtask

  // Whole run is near 720 cycles
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_logic();
    t_expand();
    t_compact();
    t_merge_permute();
    t_noflag();
    t_bus();
    tally_and_finish();
  end
endmodule
